// File: core/cms_addr_dec.sv
`timescale 1ns/10ps
`include "cms_regs.svh"

module cms_addr_dec import cms_pkg::*; #(
    parameter int SRAM_BYTES = 512
) (
    input  cms_acc_s    acc,
    output logic [15:0] eff_addr,
    output cms_region_e region,
    output logic [15:0] ptr_new,
    output logic        ptr_wr
);

    // ============================================================
    // Address forming
    wire [15:0] disp_ext = {10'h000, acc.disp};
    wire        disp_ok  = (acc.sel != CMS_PTR_X);
    wire [15:0] ptr_dec  = acc.ptr - 16'h0001;
    wire [15:0] ptr_inc  = acc.ptr + 16'h0001;
    wire [15:0] io_addr  = {10'h000, acc.addr[5:0]} + `CMS_IO_BASE;
    wire [15:0] sram_end = 16'(`CMS_SRAM_BASE + SRAM_BYTES);

    always_comb begin
        unique case (acc.mode)
            CMS_M_DIRECT:   eff_addr = acc.addr;
            CMS_M_DISP:     eff_addr = acc.ptr + (disp_ok ? disp_ext : 16'h0000);
            CMS_M_PREDEC:   eff_addr = ptr_dec;
            CMS_M_IO_SHORT: eff_addr = io_addr;
            default:        eff_addr = acc.ptr;
        endcase
    end

    assign ptr_wr  = (acc.mode == CMS_M_PREDEC) || (acc.mode == CMS_M_POSTINC);
    assign ptr_new = (acc.mode == CMS_M_PREDEC) ? ptr_dec : ptr_inc;

    // ============================================================
    // Region decode
    assign region = (eff_addr < `CMS_IO_BASE)   ? CMS_REG_FILE :
                    (eff_addr < `CMS_EXT_BASE)  ? CMS_STD_IO   :
                    (eff_addr < `CMS_SRAM_BASE) ? CMS_EXT_IO   :
                    (eff_addr < sram_end)       ? CMS_SRAM     : CMS_UNMAPPED;

endmodule

// File: core/cms_pkg.sv
package cms_pkg;

    typedef enum logic [3:0] {
        CMS_RUN = 4'b0001,
        CMS_WAKE = 4'b0010,
        CMS_ENT = 4'b0100,
        CMS_RET = 4'b1000
    } cms_state_e;

    typedef enum logic [2:0] {
        CMS_REG_FILE = 3'h0,
        CMS_STD_IO = 3'h1,
        CMS_EXT_IO = 3'h2,
        CMS_SRAM = 3'h3,
        CMS_UNMAPPED = 3'h4
    } cms_region_e;

    typedef enum logic [2:0] {
        CMS_M_DIRECT = 3'h0,
        CMS_M_DISP = 3'h1,
        CMS_M_IND = 3'h2,
        CMS_M_PREDEC = 3'h3,
        CMS_M_POSTINC = 3'h4,
        CMS_M_IO_SHORT = 3'h5
    } cms_mode_e;

    typedef enum logic [1:0] {
        CMS_PTR_X = 2'h0,
        CMS_PTR_Y = 2'h1,
        CMS_PTR_Z = 2'h2
    } cms_ptr_e;

    typedef struct packed {
        logic boundary;
        logic is_sei;
        logic is_cli;
        logic is_irq_return_instr;
        logic sleeping;
        logic ee_rd;
        logic ee_wr;
        logic sram_acc;
    } cms_instr_s;

    typedef struct packed {
        cms_mode_e   mode;
        cms_ptr_e    sel;
        logic [15:0] ptr;
        logic [5:0]  disp;
        logic [15:0] addr;
    } cms_acc_s;

    typedef struct packed {
        logic       push;
        logic       pop;
        logic [7:0] data;
    } cms_stack_s;

endpackage

// File: core/cms_regs.svh
`ifndef CMS_REGS_SVH
`define CMS_REGS_SVH

// ============================================================
// Timing counts
`define CMS_CLK_MHZ        100
`define CMS_ENTRY_CYC      3'd4
`define CMS_WAKE_CYC       3'd4
`define CMS_IRQ_RETURN_INSTR_CYC       3'd4
`define CMS_EE_RD_STALL    3'd4
`define CMS_EE_WR_STALL    3'd2
`define CMS_EE_WR_TIME_US  3400
`define CMS_EE_WR_CYC      (`CMS_EE_WR_TIME_US * `CMS_CLK_MHZ)

// ============================================================
// Data space layout
`define CMS_IO_BASE        16'h0020
`define CMS_EXT_BASE       16'h0060
`define CMS_SRAM_BASE      16'h0100
`define CMS_DISP_MAX       6'h3f
`define CMS_VEC_STEP       2

`endif

// File: core/cms_seq.sv
`timescale 1ns/10ps
`include "cms_regs.svh"

// Overview of operation
// - After sei, one more instruction runs first
// - Interrupt entry lasts four cycles, then vector
// - Entry pushes program counter onto stack
// - Multi-cycle instruction finishes before entry starts
// - Wake from sleep adds four entry cycles
// - Return takes four cycles, pops PC, sets gie
// - Program counter 11/12/13 bits per variant
// - Decode register file, I/O, extended, SRAM
// - Extended I/O unreachable by short I/O
// - Displacement up to 63 from Y or Z
// - X/Y/Z pointers pre-decrement and post-increment
// - Direct addressing reaches whole data space
// - SRAM access completes in two cycles
// - EEPROM read stalls core four cycles
// - EEPROM write stalls core two cycles
// - EEPROM byte space, self-timed write busy
// - EEPROM write survives rst_n reset until done; power-on reset (por_n) clears it
// - Larger variants split boot and application
// - Entry clears global interrupt enable
// - After return, one main instruction first
// - Cli blocks interrupts at once, same cycle
// - Lowest vector number wins among pending
module cms_seq import cms_pkg::*; #(
    parameter int VARIANT   = 0,
    parameter int N_IRQ     = 25,
    parameter int BOOT_WORD = 1024,
    parameter int EE_WR_CYC = `CMS_EE_WR_CYC,
    localparam int PC_W     = 11 + VARIANT,
    localparam int EE_AW    = (VARIANT == 0) ? 8 : 9,
    localparam int SRAM_B   = (VARIANT == 0) ? 512 : 1024
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              por_n,
    input  wire cms_instr_s        instr,
    input  wire logic [N_IRQ-1:0]  irq_req,
    input  wire logic [PC_W-1:0]   pc_now,
    input  wire logic [7:0]        pop_data,
    input  wire cms_acc_s          acc,
    input  wire logic [9:0]        ee_addr_in,
    output cms_stack_s             stk,
    output logic                   gie,
    output logic                   fetch_hold,
    output logic                   irq_ack,
    output logic [4:0]             irq_id,
    output logic                   pc_load,
    output logic [PC_W-1:0]        pc_value,
    output logic                   sram_done,
    output logic                   ee_busy,
    output logic [EE_AW-1:0]       ee_addr,
    output logic                   in_boot,
    output logic [15:0]            eff_addr,
    output cms_region_e            region,
    output logic [15:0]            ptr_new,
    output logic                   ptr_wr
);

    if (VARIANT < 0 || VARIANT > 2 || N_IRQ < 1 || N_IRQ > 31 || EE_WR_CYC < 1) begin : g_bad
        $error("cms_seq: unsupported parameter value");
    end

    // ============================================================
    // Reset synchronisers
    logic rst_s1, rst_s2, por_s1, por_s2;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    always_ff @(posedge clk or negedge por_n) begin
        if (!por_n) begin
            por_s1 <= 1'b0;
            por_s2 <= 1'b0;
        end else begin
            por_s1 <= 1'b1;
            por_s2 <= por_s1;
        end
    end

    // ============================================================
    // Interrupt selection
    function automatic logic [4:0] first_set(input logic [N_IRQ-1:0] v);
        first_set = 5'h00;
        for (int i = N_IRQ - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 5'(i);
            end
        end
    endfunction

    cms_state_e        state;
    logic [2:0]        cnt;
    logic [2:0]        stall_cnt;
    logic              block;
    logic [15:0]       ret_pc;
    logic [31:0]       ee_wr_cnt;

    wire any_irq  = |irq_req;
    wire stalled  = (stall_cnt != 3'h0);
    wire ee_wr_ok = instr.ee_wr && !ee_busy;
    // Cli in the same cycle blocks the take; multi-cycle ops only expose boundary at the end
    wire take     = (state == CMS_RUN) && gie && any_irq && !instr.is_cli &&
                    instr.boundary && !block && !stalled && !instr.sleeping;
    wire wake     = (state == CMS_RUN) && gie && any_irq && instr.sleeping;
    wire ret_go   = (state == CMS_RUN) && instr.is_irq_return_instr && instr.boundary && !take;
    wire [4:0] sel_id = first_set(irq_req);
    wire [PC_W-1:0] vec_lat = PC_W'((32'(irq_id) + 32'd1) * `CMS_VEC_STEP);

    // ============================================================
    // Sequencer state machine
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            state <= CMS_RUN;
            cnt   <= 3'h0;
        end else begin
            unique case (state)
                CMS_RUN: begin
                    if (take) begin
                        state <= CMS_ENT;
                        cnt   <= `CMS_ENTRY_CYC - 3'd1;
                    end else if (wake) begin
                        state <= CMS_WAKE;
                        cnt   <= `CMS_WAKE_CYC - 3'd1;
                    end else if (ret_go) begin
                        state <= CMS_RET;
                        cnt   <= `CMS_IRQ_RETURN_INSTR_CYC - 3'd1;
                    end
                end
                CMS_WAKE: begin
                    cnt <= (cnt == 3'h0) ? `CMS_ENTRY_CYC - 3'd1 : cnt - 3'd1;
                    if (cnt == 3'h0) begin
                        state <= CMS_ENT;
                    end
                end
                default: begin
                    cnt <= cnt - 3'd1;
                    if (cnt == 3'h0) begin
                        state <= CMS_RUN;
                    end
                end
            endcase
        end
    end

    // ============================================================
    // Global enable, one-instruction block, stack traffic
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            gie      <= 1'b0;
            block    <= 1'b0;
            irq_ack  <= 1'b0;
            irq_id   <= 5'h00;
            stk      <= '0;
            ret_pc   <= 16'h0000;
            pc_load  <= 1'b0;
            pc_value <= '0;
        end else begin
            irq_ack <= take || wake;
            stk     <= '0;
            pc_load <= 1'b0;
            if (take || wake) begin
                gie    <= 1'b0;
                irq_id <= sel_id;
            end else if (instr.is_cli && instr.boundary) begin
                gie <= 1'b0;
            end else if (instr.is_sei && instr.boundary && state == CMS_RUN) begin
                gie   <= 1'b1;
                block <= 1'b1;
            end else if (instr.boundary) begin
                block <= 1'b0;
            end
            if (state == CMS_ENT && cnt == 3'd3) begin
                stk <= '{push: 1'b1, pop: 1'b0, data: 8'(pc_now)};
            end
            if (state == CMS_ENT && cnt == 3'd2) begin
                stk <= '{push: 1'b1, pop: 1'b0, data: 8'(16'(pc_now) >> 8)};
            end
            if (state == CMS_ENT && cnt == 3'h0) begin
                pc_load  <= 1'b1;
                pc_value <= vec_lat;
            end
            if (state == CMS_RET && (cnt == 3'd3 || cnt == 3'd2)) begin
                stk <= '{push: 1'b0, pop: 1'b1, data: 8'h00};
            end
            if (stk.pop && cnt == 3'd2) begin
                ret_pc[15:8] <= pop_data;
            end
            if (stk.pop && cnt == 3'd1) begin
                ret_pc[7:0] <= pop_data;
            end
            if (state == CMS_RET && cnt == 3'h0) begin
                gie      <= 1'b1;
                block    <= 1'b1;
                pc_load  <= 1'b1;
                pc_value <= ret_pc[PC_W-1:0];
            end
        end
    end

    // ============================================================
    // Stall counter, SRAM timing, boot section
    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            stall_cnt  <= 3'h0;
            fetch_hold <= 1'b0;
            sram_done  <= 1'b0;
            in_boot    <= 1'b0;
            ee_addr    <= '0;
        end else begin
            if (instr.ee_rd) begin
                stall_cnt <= `CMS_EE_RD_STALL;
            end else if (ee_wr_ok) begin
                stall_cnt <= `CMS_EE_WR_STALL;
            end else if (stalled) begin
                stall_cnt <= stall_cnt - 3'd1;
            end
            fetch_hold <= instr.ee_rd || ee_wr_ok || (stall_cnt > 3'd1) ||
                          take || wake || ret_go || (state != CMS_RUN && cnt != 3'h0);
            sram_done  <= instr.sram_acc;
            in_boot    <= (VARIANT > 0) && (32'(pc_now) >= BOOT_WORD);
            ee_addr    <= ee_addr_in[EE_AW-1:0];
        end
    end

    // ============================================================
    // Self-timed EEPROM write, held only by power-on reset
    always_ff @(posedge clk or negedge por_s2) begin
        if (!por_s2) begin
            ee_wr_cnt <= 32'h0000_0000;
            ee_busy   <= 1'b0;
        end else begin
            if (ee_wr_ok) begin
                ee_wr_cnt <= 32'(EE_WR_CYC);
                ee_busy   <= 1'b1;
            end else if (ee_wr_cnt != 32'h0000_0000) begin
                ee_wr_cnt <= ee_wr_cnt - 32'h0000_0001;
                ee_busy   <= (ee_wr_cnt != 32'h0000_0001);
            end
        end
    end

    // ============================================================
    // Data address decode
    logic [15:0] dec_addr, dec_ptr;
    cms_region_e dec_region;
    logic        dec_ptr_wr;

    cms_addr_dec #(
        .SRAM_BYTES(SRAM_B)
    ) u_dec (
        .acc     (acc),
        .eff_addr(dec_addr),
        .region  (dec_region),
        .ptr_new (dec_ptr),
        .ptr_wr  (dec_ptr_wr)
    );

    always_ff @(posedge clk or negedge rst_s2) begin
        if (!rst_s2) begin
            eff_addr <= 16'h0000;
            region   <= CMS_REG_FILE;
            ptr_new  <= 16'h0000;
            ptr_wr   <= 1'b0;
        end else begin
            eff_addr <= dec_addr;
            region   <= dec_region;
            ptr_new  <= dec_ptr;
            ptr_wr   <= dec_ptr_wr;
        end
    end

    // ============================================================
    // Checks
    property p_entry_len;
        @(posedge clk) disable iff (!rst_s2)
        take |=> (state == CMS_ENT) [*4] ##1 (state == CMS_RUN && pc_load);
    endproperty
    a_entry_len: assert property (p_entry_len) else $error("entry not four cycles");

    property p_gie_clr;
        @(posedge clk) disable iff (!rst_s2)
        take |=> !gie;
    endproperty
    a_gie_clr: assert property (p_gie_clr) else $error("gie kept on entry");

    property p_cli_now;
        @(posedge clk) disable iff (!rst_s2)
        (instr.is_cli && instr.boundary) |=> !irq_ack && !gie;
    endproperty
    a_cli_now: assert property (p_cli_now) else $error("irq taken with cli");

    property p_wake_len;
        @(posedge clk) disable iff (!rst_s2)
        wake |=> (state == CMS_WAKE) [*4] ##1 (state == CMS_ENT) [*4];
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("wake not four extra");

    property p_irq_return_instr;
        @(posedge clk) disable iff (!rst_s2)
        ret_go |=> ##1 stk.pop ##1 stk.pop ##2 (gie && pc_load);
    endproperty
    a_irq_return_instr: assert property (p_irq_return_instr) else $error("return sequence wrong");

    property p_push;
        @(posedge clk) disable iff (!rst_s2)
        take |=> ##1 (stk.push [*2]);
    endproperty
    a_push: assert property (p_push) else $error("pc not pushed");

    property p_ee_rd;
        @(posedge clk) disable iff (!rst_s2)
        instr.ee_rd |=> (stall_cnt != 3'h0) [*4] ##1 (stall_cnt == 3'h0);
    endproperty
    a_ee_rd: assert property (p_ee_rd) else $error("read stall not four");

    property p_ee_wr;
        @(posedge clk) disable iff (!rst_s2)
        (ee_wr_ok && !instr.ee_rd) |=> (stall_cnt != 3'h0) [*2] ##1 (stall_cnt == 3'h0);
    endproperty
    a_ee_wr: assert property (p_ee_wr) else $error("write stall not two");

    property p_sram;
        @(posedge clk) disable iff (!rst_s2)
        instr.sram_acc |=> sram_done;
    endproperty
    a_sram: assert property (p_sram) else $error("sram not two cycles");

    property p_block;
        @(posedge clk) disable iff (!rst_s2)
        (state == CMS_RET && cnt == 3'h0) |=> !take;
    endproperty
    a_block: assert property (p_block) else $error("irq before main instr");

endmodule

// File: verification/cms_stack_model.sv
`timescale 1ns/10ps

// ============================================================
// Stack side of data SRAM
module cms_stack_model import cms_pkg::*; (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire cms_stack_s stk,
    output logic [7:0]      pop_data
);
    logic [7:0] mem [16];
    logic [3:0] sp;

    // Outside a pop the line shows the inverse, never a held value
    assign pop_data = stk.pop ? mem[sp + 4'h1] : ~mem[sp + 4'h1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sp <= 4'hf;
        end else if (stk.push) begin
            mem[sp] <= stk.data;
            sp      <= sp - 4'h1;
        end else if (stk.pop) begin
            sp <= sp + 4'h1;
        end
    end
endmodule

// File: verification/tb.sv
`timescale 1ns/10ps

module tb import cms_pkg::*; ;
    logic        clk, rst_n, por_n;
    cms_instr_s  instr;
    logic [24:0] irq_req;
    logic [10:0] pc_now, pc_value;
    logic [7:0]  pop_data, ee_addr;
    cms_acc_s    acc;
    logic [9:0]  ee_addr_in;
    cms_stack_s  stk;
    logic        gie, fetch_hold, irq_ack, pc_load, sram_done, ee_busy, in_boot, ptr_wr;
    logic [4:0]  irq_id;
    logic [15:0] eff_addr, ptr_new;
    cms_region_e region;
    int          errors, num_checks;

    cms_seq #(.VARIANT(0), .N_IRQ(25), .BOOT_WORD(1024), .EE_WR_CYC(40)) dut (
        .clk(clk), .rst_n(rst_n), .por_n(por_n), .instr(instr), .irq_req(irq_req),
        .pc_now(pc_now), .pop_data(pop_data), .acc(acc), .ee_addr_in(ee_addr_in),
        .stk(stk), .gie(gie), .fetch_hold(fetch_hold), .irq_ack(irq_ack), .irq_id(irq_id),
        .pc_load(pc_load), .pc_value(pc_value), .sram_done(sram_done), .ee_busy(ee_busy),
        .ee_addr(ee_addr), .in_boot(in_boot), .eff_addr(eff_addr), .region(region),
        .ptr_new(ptr_new), .ptr_wr(ptr_wr)
    );

    cms_stack_model stack (.clk(clk), .rst_n(rst_n), .stk(stk), .pop_data(pop_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ============================================================
    // Shared helpers
    task step;
        @(posedge clk);
        #1;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task print_verdict;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task hang_cut;
        errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, 16'h0, 16'h1);
        print_verdict;
    endtask

    // Holds a boundary until taken, then records pushes and vector load
    task take_irq(input logic [4:0] id, input int gap);
        int         ta, tp, np;
        logic [7:0] pb [2];
        ta = -1;
        tp = -1;
        np = 0;
        instr.boundary = 1'b1;
        for (int i = 0; i < 20 && tp < 0; i++) begin
            step;
            if (irq_ack === 1'b1 && ta < 0) begin
                ta = i;
                instr = '0;
                chk(16'(irq_id), 16'(id));
                chk(16'(gie), 16'h0);
            end
            if (stk.push === 1'b1 && np < 2) begin
                pb[np] = stk.data;
                np++;
            end
            if (pc_load === 1'b1) begin
                tp = i;
                chk(16'(pc_value), 16'((int'(id) + 1) * 2));
            end
        end
        if (tp < 0 || ta < 0) hang_cut;
        chk(16'(tp - ta), 16'(gap));
        chk(16'(np), 16'h2);
        chk({pb[1], pb[0]}, 16'(pc_now));
    endtask

    task irq_return_instr_op(input logic [10:0] ret);
        int         tp, np;
        logic [7:0] pb [2];
        tp = -1;
        np = 0;
        instr.boundary = 1'b1;
        instr.is_irq_return_instr = 1'b1;
        for (int i = 0; i < 10 && tp < 0; i++) begin
            step;
            instr = '0;
            if (stk.pop === 1'b1 && np < 2) begin
                pb[np] = pop_data;
                np++;
            end
            if (pc_load === 1'b1) begin
                tp = i;
                chk(16'(pc_value), 16'(ret));
                chk(16'(gie), 16'h1);
            end
        end
        if (tp < 0) hang_cut;
        chk(16'(tp), 16'h4);
        chk({pb[0], pb[1]}, 16'(ret));
    endtask

    task dec(input cms_mode_e m, input cms_ptr_e s, input logic [15:0] p,
             input logic [5:0] d, input logic [15:0] a, input logic [15:0] e,
             input cms_region_e r, input logic w, input logic [15:0] n);
        acc.mode = m;
        acc.sel = s;
        acc.ptr = p;
        acc.disp = d;
        acc.addr = a;
        step;
        chk(eff_addr, e);
        chk(16'(region), 16'(r));
        chk(16'(ptr_wr), 16'(w));
        if (w) chk(ptr_new, n);
    endtask

    task ee_stall(input logic wr, input int n);
        instr.ee_wr = wr;
        instr.ee_rd = ~wr;
        for (int i = 1; i <= 5; i++) begin
            step;
            instr = '0;
            chk(16'(fetch_hold), 16'(i <= n));
        end
    endtask

    // ============================================================
    // Scenarios
    task t_decode;
        chk(16'(dut.PC_W), 16'd11);
        dec(CMS_M_DIRECT, CMS_PTR_X, 16'h0, 6'h0, 16'h001f, 16'h001f, CMS_REG_FILE, 1'b0, 16'h0);
        dec(CMS_M_DIRECT, CMS_PTR_X, 16'h0, 6'h0, 16'h0020, 16'h0020, CMS_STD_IO, 1'b0, 16'h0);
        dec(CMS_M_DIRECT, CMS_PTR_X, 16'h0, 6'h0, 16'h005f, 16'h005f, CMS_STD_IO, 1'b0, 16'h0);
        dec(CMS_M_DIRECT, CMS_PTR_X, 16'h0, 6'h0, 16'h0060, 16'h0060, CMS_EXT_IO, 1'b0, 16'h0);
        dec(CMS_M_DIRECT, CMS_PTR_X, 16'h0, 6'h0, 16'h00ff, 16'h00ff, CMS_EXT_IO, 1'b0, 16'h0);
        dec(CMS_M_DIRECT, CMS_PTR_X, 16'h0, 6'h0, 16'h0100, 16'h0100, CMS_SRAM, 1'b0, 16'h0);
        dec(CMS_M_DIRECT, CMS_PTR_X, 16'h0, 6'h0, 16'h02ff, 16'h02ff, CMS_SRAM, 1'b0, 16'h0);
        dec(CMS_M_DIRECT, CMS_PTR_X, 16'h0, 6'h0, 16'h0300, 16'h0300, CMS_UNMAPPED, 1'b0, 16'h0);
        dec(CMS_M_IO_SHORT, CMS_PTR_X, 16'h0, 6'h0, 16'h003f, 16'h005f, CMS_STD_IO, 1'b0, 16'h0);
        dec(CMS_M_IO_SHORT, CMS_PTR_X, 16'h0, 6'h0, 16'h0000, 16'h0020, CMS_STD_IO, 1'b0, 16'h0);
        dec(CMS_M_DISP, CMS_PTR_Y, 16'h0100, 6'h3f, 16'h0, 16'h013f, CMS_SRAM, 1'b0, 16'h0);
        dec(CMS_M_DISP, CMS_PTR_Z, 16'h0060, 6'h01, 16'h0, 16'h0061, CMS_EXT_IO, 1'b0, 16'h0);
        dec(CMS_M_DISP, CMS_PTR_X, 16'h0150, 6'h05, 16'h0, 16'h0150, CMS_SRAM, 1'b0, 16'h0);
        dec(CMS_M_IND, CMS_PTR_Z, 16'h0040, 6'h0, 16'h0, 16'h0040, CMS_STD_IO, 1'b0, 16'h0);
        dec(CMS_M_PREDEC, CMS_PTR_X, 16'h0101, 6'h0, 16'h0, 16'h0100, CMS_SRAM, 1'b1, 16'h0100);
        dec(CMS_M_POSTINC, CMS_PTR_Y, 16'h00ff, 6'h0, 16'h0, 16'h00ff, CMS_EXT_IO, 1'b1, 16'h0100);
        dec(CMS_M_PREDEC, CMS_PTR_Z, 16'h0020, 6'h0, 16'h0, 16'h001f, CMS_REG_FILE, 1'b1, 16'h001f);
        $display("test decode done");
    endtask

    task t_sram;
        instr.sram_acc = 1'b1;
        step;
        instr = '0;
        chk(16'(sram_done), 16'h1);
        step;
        chk(16'(sram_done), 16'h0);
        $display("test sram done");
    endtask

    task t_irq;
        pc_now = 11'h5a3;
        irq_req = 25'h28;
        instr.boundary = 1'b1;
        instr.is_sei = 1'b1;
        step;
        instr.is_sei = 1'b0;
        step;
        chk(16'(irq_ack), 16'h0);
        instr = '0;
        for (int i = 0; i < 3; i++) begin
            step;
            chk(16'(irq_ack), 16'h0);
        end
        take_irq(5'd3, 4);
        chk(16'(in_boot), 16'h0);
        irq_req = 25'h20;
        pc_now = 11'h412;
        irq_return_instr_op(11'h5a3);
        instr.boundary = 1'b1;
        step;
        chk(16'(irq_ack), 16'h0);
        take_irq(5'd5, 4);
        irq_req = '0;
        irq_return_instr_op(11'h412);
        $display("test irq done");
    endtask

    task t_cli;
        // One plain boundary first, so the block after return is gone
        instr.boundary = 1'b1;
        step;
        irq_req = 25'h1;
        instr.is_cli = 1'b1;
        for (int i = 0; i < 3; i++) begin
            step;
            instr.is_cli = 1'b0;
            chk(16'(irq_ack), 16'h0);
        end
        chk(16'(gie), 16'h0);
        irq_req = '0;
        instr = '0;
        $display("test cli done");
    endtask

    task t_sleep;
        instr.boundary = 1'b1;
        instr.is_sei = 1'b1;
        step;
        instr.is_sei = 1'b0;
        step;
        instr = '0;
        instr.sleeping = 1'b1;
        step;
        irq_req = 25'h4;
        take_irq(5'd2, 8);
        irq_req = '0;
        irq_return_instr_op(pc_now);
        $display("test sleep done");
    endtask

    task t_ee;
        ee_addr_in = 10'h2a5;
        ee_stall(1'b0, 4);
        // Write pulse stands for a completed protected sequence
        ee_stall(1'b1, 2);
        chk(16'(ee_busy), 16'h1);
        chk(16'(ee_addr), 16'h00a5);
        ee_stall(1'b1, 0);
        rst_n = 1'b0;
        repeat (3) step;
        rst_n = 1'b1;
        repeat (3) step;
        chk(16'(ee_busy), 16'h1);
        chk(16'(gie), 16'h0);
        for (int i = 0; i < 80 && ee_busy !== 1'b0; i++) step;
        if (ee_busy !== 1'b0) hang_cut;
        chk(16'(ee_busy), 16'h0);
        $display("test eeprom done");
    endtask

    // ============================================================
    // Main sequence
    initial begin
        errors = 0;
        num_checks = 0;
        rst_n = 1'b0;
        por_n = 1'b0;
        instr = '0;
        irq_req = '0;
        pc_now = '0;
        acc = '0;
        ee_addr_in = '0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        por_n = 1'b1;
        repeat (3) step;
        t_decode;
        t_sram;
        t_irq;
        t_cli;
        t_sleep;
        t_ee;
        print_verdict;
    end
endmodule
